// File: design/crs_pkg.sv
/*
 * constants, carrier structs and state type of the clock and reset sequencer.
 * assumes a single 40 MHz clk_sys and 32-bit Avalon-MM register access.
 */
package crs_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS  = 25000;
   localparam int unsigned RC_SETTLE_US   = 100;
   localparam int unsigned XTAL_STAB_US   = 2500;
   localparam int unsigned RC_SETTLE_CYC  = (RC_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned XTAL_STAB_CYC  = (XTAL_STAB_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned CNT_W          = 17;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_CAL    = 4'h8;

   // ctrl fields
   localparam int unsigned CTRL_SW_RST  = 0;
   localparam int unsigned CTRL_RST_OUT = 1;
   localparam int unsigned CTRL_CLK_X2  = 2;
   localparam int unsigned CTRL_BOD_RST = 3;
   localparam int unsigned CTRL_BOD_IRQ = 4;
   localparam int unsigned CTRL_THR_LSB = 5;

   // status fields
   localparam int unsigned STAT_CAUSE_LSB = 0;
   localparam int unsigned STAT_STATE_LSB = 4;
   localparam int unsigned STAT_BOD_LOW   = 6;

   // cause bit positions
   localparam int unsigned CAUSE_POR = 0;
   localparam int unsigned CAUSE_EXT = 1;
   localparam int unsigned CAUSE_SW  = 2;
   localparam int unsigned CAUSE_BOD = 3;

   localparam int unsigned CAL_W = 16;

   // reset values
   localparam logic [31:0] RESET_VEC     = 32'h0000_0100;
   localparam logic [1:0]  BOD_THR_RST   = 2'h0;
   localparam logic [3:0]  CAUSE_RST     = 4'h1;
   localparam logic [CAL_W-1:0] CAL_RST  = 16'h0000;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      BOD_2V1,
      BOD_2V4,
      BOD_2V5,
      BOD_2V6
   } crs_bod_thr_t;

   typedef enum logic [1:0] {
      ST_HOLD,
      ST_RC,
      ST_XTAL,
      ST_RUN
   } crs_fsm_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [31:0] writedata;
   } crs_avm_req_t;

   typedef struct packed {
      logic        waitrequest;
      logic [31:0] readdata;
   } crs_avm_rsp_t;

   typedef struct packed {
      crs_fsm_t          fsm;
      logic [CNT_W-1:0]  cnt;
      logic              rst_out_en;
      logic              clk_x2;
      logic              bod_rst_en;
      logic              bod_irq_en;
      crs_bod_thr_t      bod_thr;
      logic [CAL_W-1:0]  cal;
      logic [3:0]        cause;
      logic              por_drive;
      logic              sw_drive;
      logic              bod_prev;
      logic              waitreq;
      logic [31:0]       rdata;
      logic              line_oe;
      logic              core_rst_b;
      logic              rc_clk_sel;
      logic              xtal_en;
      logic              logic_pwr;
      logic              xtal_ref;
      logic              cpu_x2;
      logic              bod_on;
      logic              bod_irq;
      logic [31:0]       vec;
   } crs_state_t;

endpackage : crs_pkg

// File: design/crs_top.sv
/*
 * clock and reset sequencer: merges the reset sources, runs the oscillator
 * start-up sequence, drives the shared open-drain reset line and hosts the
 * brown-out and clock option registers on an Avalon-MM slave.
 * assumes synchronous inputs and a testbench that resolves the shared line.
 */
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps

//
// Notes on behaviour
// - let the slow oscillator settle 100us before enabling crystal and logic power
// - hold core logic in reset for the crystal stabilisation wait of 2.5ms
// - after the crystal is stable release internal reset so the processor runs
// - processor starts at reset vector 0x100 after any reset
// - exactly four reset sources: power-on, external line, software, brown-out
// - power-on reset held while supply low, then full stabilisation wait
// - drive the shared reset line low while the power-on reset is active
// - stay in reset while the external line is low; sequence starts on release
// - reset line is open-drain: only pull low or release, never drive high
// - a software request causes a full system reset at any time
// - software reset drives the line only if reset-output enabled; default off
// - brown-out detector works while awake or in processor doze
// - when enabled a brown-out dip below threshold causes a chip reset
// - when enabled brown-out crossings in either direction raise an interrupt
// - brown-out threshold selectable among 2.1V, 2.4V, 2.5V, 2.6V
// - logic runs from the slow clock during reset; it also times sleep
// - crystal 16MHz clock is the reference for processor and peripherals
// - processor, RAM and ROM clock can be switched to the doubled 32MHz clock
// - sleep timing accepts a software calibration factor against the crystal
module crs_top
   import crs_pkg::*;
#(
   parameter int unsigned XTAL_CYC = XTAL_STAB_CYC
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_b,
   // register bus
   input  wire crs_avm_req_t      avm_req,
   output      crs_avm_rsp_t      avm_rsp,
   // analog detectors and processor state
   input  wire logic              supply_low,
   input  wire logic              bod_below,
   input  wire logic              cpu_awake,
   input  wire logic              cpu_doze,
   // shared open-drain reset line
   input  wire logic              system_reset_line_in,
   output      logic              system_reset_line_out,
   output      logic              system_reset_line_oe,
   // clock and power controls
   output      logic              core_rst_b,
   output      logic              rc_clk_sel,
   output      logic              xtal_en,
   output      logic              logic_pwr_en,
   output      logic              xtal_ref_en,
   output      logic              cpu_clk_x2,
   output      logic [31:0]       reset_vector,
   // brown-out
   output      logic              bod_enable,
   output      logic [1:0]        bod_threshold,
   output      logic              bod_irq,
   // sleep timer calibration
   output      logic [CAL_W-1:0]  sleep_cal
);

   localparam logic [CNT_W-1:0] RC_LAST   = CNT_W'(RC_SETTLE_CYC - 1);
   localparam logic [CNT_W-1:0] XTAL_LAST = CNT_W'(XTAL_CYC - 1);

   localparam crs_state_t ST_RESET = '{
      fsm        : ST_HOLD,
      bod_thr    : crs_bod_thr_t'(BOD_THR_RST),
      cal        : CAL_RST,
      cause      : CAUSE_RST,
      por_drive  : 1'b1,
      waitreq    : 1'b1,
      line_oe    : 1'b1,
      rc_clk_sel : 1'b1,
      vec        : RESET_VEC,
      default    : '0
   };

   crs_state_t st_r;
   crs_state_t st_nxt;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic       acc;
      logic       wr_ctrl;
      logic [3:0] src;
      logic       bod_fall;
      logic       bod_rise;
      acc      = avm_req.read | avm_req.write;
      wr_ctrl  = 1'b0;
      src      = 4'h0;
      bod_fall = 1'b0;
      bod_rise = 1'b0;
      st_nxt   = st_r;

      // brown-out edges
      st_nxt.bod_prev = bod_below;
      bod_fall = bod_below & ~st_r.bod_prev;
      bod_rise = ~bod_below & st_r.bod_prev;
      st_nxt.bod_irq = st_r.bod_on & st_r.bod_irq_en & (bod_fall | bod_rise);

      // bus slave: one cycle of waitrequest high, then one cycle low
      st_nxt.waitreq = 1'b1;
      if (acc && st_r.waitreq) begin
         st_nxt.waitreq = 1'b0;
         st_nxt.rdata   = 32'h0000_0000;
         if (avm_req.read) begin
            unique case (avm_req.address)
               ADDR_CTRL: begin
                  st_nxt.rdata[CTRL_RST_OUT]       = st_r.rst_out_en;
                  st_nxt.rdata[CTRL_CLK_X2]        = st_r.clk_x2;
                  st_nxt.rdata[CTRL_BOD_RST]       = st_r.bod_rst_en;
                  st_nxt.rdata[CTRL_BOD_IRQ]       = st_r.bod_irq_en;
                  st_nxt.rdata[CTRL_THR_LSB +: 2]  = st_r.bod_thr;
               end
               ADDR_STATUS: begin
                  st_nxt.rdata[STAT_CAUSE_LSB +: 4] = st_r.cause;
                  st_nxt.rdata[STAT_STATE_LSB +: 2] = st_r.fsm;
                  st_nxt.rdata[STAT_BOD_LOW]        = bod_below;
               end
               ADDR_CAL:
                  st_nxt.rdata[CAL_W-1:0] = st_r.cal;
               default: ;
            endcase
         end
      end

      // a write lands only at the edge where waitrequest is seen low
      if (avm_req.write && !st_r.waitreq) begin
         unique case (avm_req.address)
            ADDR_CTRL: begin
               wr_ctrl           = 1'b1;
               st_nxt.rst_out_en = avm_req.writedata[CTRL_RST_OUT];
               st_nxt.clk_x2     = avm_req.writedata[CTRL_CLK_X2];
               st_nxt.bod_rst_en = avm_req.writedata[CTRL_BOD_RST];
               st_nxt.bod_irq_en = avm_req.writedata[CTRL_BOD_IRQ];
               st_nxt.bod_thr    = crs_bod_thr_t'(avm_req.writedata[CTRL_THR_LSB +: 2]);
            end
            ADDR_STATUS:
               st_nxt.cause = st_r.cause & ~avm_req.writedata[STAT_CAUSE_LSB +: 4];
            ADDR_CAL:
               st_nxt.cal = avm_req.writedata[CAL_W-1:0];
            default: ;
         endcase
      end

      // the four reset sources
      src[CAUSE_POR] = supply_low;
      src[CAUSE_EXT] = ~system_reset_line_in & ~st_r.line_oe;
      src[CAUSE_SW]  = wr_ctrl & avm_req.writedata[CTRL_SW_RST];
      src[CAUSE_BOD] = st_r.bod_on & st_r.bod_rst_en & bod_fall;

      if (|src) begin
         st_nxt.fsm   = ST_HOLD;
         st_nxt.cnt   = '0;
         st_nxt.cause = st_nxt.cause | src;
         if (src[CAUSE_POR]) begin
            st_nxt.por_drive = 1'b1;
         end
         if (src[CAUSE_SW] && st_r.rst_out_en) begin
            st_nxt.sw_drive = 1'b1;
         end
         // full reset returns the options to their defaults
         st_nxt.rst_out_en = 1'b0;
         st_nxt.clk_x2     = 1'b0;
         st_nxt.bod_rst_en = 1'b0;
         st_nxt.bod_irq_en = 1'b0;
         st_nxt.bod_thr    = crs_bod_thr_t'(BOD_THR_RST);
         st_nxt.bod_irq    = 1'b0;
      end else begin
         unique case (st_r.fsm)
            ST_HOLD: begin
               st_nxt.fsm = ST_RC;
               st_nxt.cnt = '0;
            end
            ST_RC: begin
               st_nxt.cnt = st_r.cnt + 1'b1;
               if (st_r.cnt == RC_LAST) begin
                  st_nxt.fsm = ST_XTAL;
                  st_nxt.cnt = '0;
               end
            end
            ST_XTAL: begin
               st_nxt.cnt = st_r.cnt + 1'b1;
               if (st_r.cnt == XTAL_LAST) begin
                  st_nxt.fsm       = ST_RUN;
                  st_nxt.cnt       = '0;
                  st_nxt.por_drive = 1'b0;
                  st_nxt.sw_drive  = 1'b0;
               end
            end
            ST_RUN: ;
         endcase
      end

      // outputs follow the next sequencer state
      st_nxt.line_oe    = st_nxt.por_drive | st_nxt.sw_drive;
      st_nxt.xtal_en    = (st_nxt.fsm == ST_XTAL) || (st_nxt.fsm == ST_RUN);
      st_nxt.logic_pwr  = st_nxt.xtal_en;
      st_nxt.core_rst_b = (st_nxt.fsm == ST_RUN);
      st_nxt.rc_clk_sel = (st_nxt.fsm != ST_RUN);
      st_nxt.xtal_ref   = (st_nxt.fsm == ST_RUN);
      st_nxt.cpu_x2     = st_nxt.core_rst_b & st_nxt.clk_x2;
      st_nxt.bod_on     = st_nxt.core_rst_b & (cpu_awake | cpu_doze);
      st_nxt.vec        = RESET_VEC;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= ST_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign avm_rsp.waitrequest   = st_r.waitreq;
   assign avm_rsp.readdata      = st_r.rdata;
   assign system_reset_line_out = 1'b0;
   assign system_reset_line_oe  = st_r.line_oe;
   assign core_rst_b            = st_r.core_rst_b;
   assign rc_clk_sel            = st_r.rc_clk_sel;
   assign xtal_en               = st_r.xtal_en;
   assign logic_pwr_en          = st_r.logic_pwr;
   assign xtal_ref_en           = st_r.xtal_ref;
   assign cpu_clk_x2            = st_r.cpu_x2;
   assign reset_vector          = st_r.vec;
   assign bod_enable            = st_r.bod_on;
   assign bod_threshold         = st_r.bod_thr;
   assign bod_irq               = st_r.bod_irq;
   assign sleep_cal             = st_r.cal;

endmodule : crs_top

// File: testbench/crs_assertions.sv
/* port checker of the clock and reset sequencer.
   assumes a bind into crs_top, one clk_sys domain. */
`timescale 1ns/1ps
module crs_assertions
   import crs_pkg::*;
#(
   parameter int unsigned XTAL_CYC = 20
) (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rst_b,
   // sources
   input wire logic        supply_low,
   input wire logic        bod_below,
   input wire logic        cpu_awake,
   input wire logic        cpu_doze,
   input wire logic        system_reset_line_in,
   // outputs
   input wire logic        system_reset_line_out,
   input wire logic        system_reset_line_oe,
   input wire logic        core_rst_b,
   input wire logic        rc_clk_sel,
   input wire logic        xtal_en,
   input wire logic        xtal_ref_en,
   input wire logic [31:0] reset_vector,
   input wire logic        bod_enable,
   input wire logic        bod_irq
);
   // ---------------
   // phase counters
   // ---------------
   int rc_n_r;
   int xt_n_r;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rc_n_r <= 0;
         xt_n_r <= 0;
      end else begin
         rc_n_r <= xtal_en ? 0 : rc_n_r + 1;
         xt_n_r <= (xtal_en && !core_rst_b) ? xt_n_r + 1 : 0;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence s_xtal_on; $rose(xtal_en); endsequence
   sequence s_run_on; $rose(core_rst_b); endsequence
   // ---------------
   // properties
   // ---------------
   AST_RC_FIRST: assert property (s_xtal_on |-> rc_n_r >= 4000)
      else $error("crystal enabled early");
   AST_XTAL_WAIT: assert property (s_run_on |-> xt_n_r == XTAL_CYC)
      else $error("crystal wait wrong");
   AST_RUN_STATE: assert property (s_run_on |-> !system_reset_line_oe && !rc_clk_sel && xtal_ref_en)
      else $error("run state wrong");
   AST_POR_HOLD: assert property (supply_low |=> !core_rst_b && system_reset_line_oe && !xtal_en)
      else $error("power-on hold wrong");
   AST_EXT_HOLD: assert property (!system_reset_line_in && !system_reset_line_oe |=> !core_rst_b && !xtal_en)
      else $error("line reset missed");
   AST_LINE_LOW: assert property (system_reset_line_out == 1'b0)
      else $error("line driven high");
   AST_VECTOR: assert property (reset_vector == 32'h0000_0100)
      else $error("reset vector wrong");
   AST_BOD_AWAKE: assert property (bod_enable |-> $past(cpu_awake || cpu_doze))
      else $error("detector on while asleep");
   AST_BOD_IRQ: assert property (bod_irq |-> $past(bod_below) != $past(bod_below, 2) ##1 !bod_irq)
      else $error("brown-out irq wrong");
endmodule : crs_assertions

bind crs_top crs_assertions #(.XTAL_CYC(XTAL_CYC)) chk_u (.clk_sys, .rst_b, .supply_low, .bod_below,
   .cpu_awake, .cpu_doze, .system_reset_line_in, .system_reset_line_out, .system_reset_line_oe,
   .core_rst_b, .rc_clk_sel, .xtal_en, .xtal_ref_en, .reset_vector, .bod_enable, .bod_irq);

// File: testbench/crs_line_partner.sv
/* other board device on the shared reset line.
   assumes a pull-up resolves the line outside. */
`timescale 1ns/1ps
module crs_line_partner (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // pulse request
   input  wire logic       go,
   input  wire logic [7:0] len,
   // line pull-down
   output      logic       pull_oe
);
   // ---------
   // low pulse
   // ---------
   logic [7:0] cnt_r;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) cnt_r <= 8'h00;
      else if (go) cnt_r <= len;
      else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
   end
   assign pull_oe = (cnt_r != 8'h00);
endmodule : crs_line_partner

// File: testbench/crs_tb_top.sv
/* self-checking bench of the clock and reset sequencer.
   assumes crs_pkg, the checker bind and the line partner. */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin fails++; $display("BAD %s exp %0h got %0h", nm, e, s); end end
module crs_tb_top;
   import crs_pkg::*;
   logic         clk_sys, rst_b, supply_low, bod_below, cpu_awake, cpu_doze, p_go, p_oe;
   logic         system_reset_line_oe, core_rst_b, rc_clk_sel, xtal_en, xtal_ref_en, cpu_clk_x2;
   logic         bod_enable, bod_irq, logic_pwr_en;
   logic [31:0]  reset_vector, q;
   logic [1:0]   bod_threshold;
   logic [15:0]  sleep_cal;
   logic [7:0]   p_len;
   crs_avm_req_t avm_req;
   crs_avm_rsp_t avm_rsp;
   int           fails, n_checks;
   wire logic    system_reset_line_in = !(system_reset_line_oe || p_oe);
   // ---------
   // structure
   // ---------
   crs_top #(.XTAL_CYC(20)) dut_u (.clk_sys, .rst_b, .avm_req, .avm_rsp, .supply_low, .bod_below,
      .cpu_awake, .cpu_doze, .system_reset_line_in, .system_reset_line_out(), .system_reset_line_oe,
      .core_rst_b, .rc_clk_sel, .xtal_en, .logic_pwr_en, .xtal_ref_en, .cpu_clk_x2, .reset_vector,
      .bod_enable, .bod_threshold, .bod_irq, .sleep_cal);
   crs_line_partner part_u (.clk_sys, .rst_b, .go(p_go), .len(p_len), .pull_oe(p_oe));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // ---------
   // tasks
   // ---------
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_sys);
      avm_req <= '{read: !w, write: w, address: a, writedata: d};
      k = 0;
      do begin @(posedge clk_sys); k++; end while (avm_rsp.waitrequest !== 1'b0 && k < 50);
      q = avm_rsp.readdata;
      avm_req <= '0;
      `CHK("ack", 1'b0, avm_rsp.waitrequest)
   endtask : bus
   task cause(input logic [3:0] e);
      bus(1'b0, ADDR_STATUS, 32'h0);
      `CHK("cause", e, q[3:0])
      bus(1'b1, ADDR_STATUS, 32'hF);
   endtask : cause
   task wait_run;
      int k;
      k = 0;
      while (core_rst_b !== 1'b1 && k < 6000) begin @(posedge clk_sys); k++; end
      @(posedge clk_sys);
      `CHK("run", 1'b1, core_rst_b)
      `CHK("pwr", 1'b1, logic_pwr_en)
      `CHK("rcsel", 1'b0, rc_clk_sel)
      `CHK("ref", 1'b1, xtal_ref_en)
      `CHK("vec", 32'h0000_0100, reset_vector)
      `CHK("oe", 1'b0, system_reset_line_oe)
   endtask : wait_run
   task t_opts;
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, ADDR_CTRL, 32'(i) << CTRL_THR_LSB | 32'h4);
         repeat (2) @(posedge clk_sys);
         `CHK("thr", i[1:0], bod_threshold)
      end
      `CHK("x2", 1'b1, cpu_clk_x2)
      bus(1'b1, ADDR_CAL, 32'hA5C3);
      bus(1'b0, ADDR_CAL, 32'h0);
      `CHK("cal", 32'hA5C3, q)
      `CHK("calo", 16'hA5C3, sleep_cal)
      bus(1'b0, 4'hC, 32'h0);
      `CHK("unmap", 32'h0, q)
      bus(1'b1, ADDR_CTRL, 32'h0);
   endtask : t_opts
   task t_por;
      supply_low <= 1'b1;
      repeat (20) @(posedge clk_sys);
      `CHK("por", 1'b0, core_rst_b)
      `CHK("poroe", 1'b1, system_reset_line_oe)
      supply_low <= 1'b0;
      repeat (100) @(posedge clk_sys);
      `CHK("rcx", 1'b0, xtal_en)
      `CHK("pwrx", 1'b0, logic_pwr_en)
      `CHK("rcs", 1'b1, rc_clk_sel)
      wait_run;
      cause(4'h1);
   endtask : t_por
   task t_ext;
      p_len <= 8'h0C;
      p_go <= 1'b1;
      @(posedge clk_sys);
      p_go <= 1'b0;
      repeat (4) @(posedge clk_sys);
      `CHK("ext", 1'b0, core_rst_b)
      `CHK("extoe", 1'b0, system_reset_line_oe)
      repeat (20) @(posedge clk_sys);
      `CHK("extx", 1'b0, xtal_en)
      wait_run;
      cause(4'h2);
   endtask : t_ext
   task t_sw;
      bus(1'b1, ADDR_CTRL, 32'h1);
      @(posedge clk_sys);
      `CHK("sw", 1'b0, core_rst_b)
      `CHK("swoe0", 1'b0, system_reset_line_oe)
      bus(1'b0, ADDR_CTRL, 32'h0);
      `CHK("ctrl", 32'h0, q)
      wait_run;
      bus(1'b1, ADDR_CTRL, 32'h2);
      bus(1'b1, ADDR_CTRL, 32'h3);
      @(posedge clk_sys);
      `CHK("swoe1", 1'b1, system_reset_line_oe)
      wait_run;
      cause(4'h4);
   endtask : t_sw
   task t_bod;
      bus(1'b1, ADDR_CTRL, 32'h10);
      repeat (2) @(posedge clk_sys);
      `CHK("boden", 1'b1, bod_enable)
      for (int i = 0; i < 2; i++) begin
         bod_below <= !bod_below;
         repeat (2) @(posedge clk_sys);
         `CHK("irq", 1'b1, bod_irq)
         @(posedge clk_sys);
         `CHK("irq0", 1'b0, bod_irq)
      end
      cpu_awake <= 1'b0;
      cpu_doze <= 1'b1;
      repeat (3) @(posedge clk_sys);
      `CHK("doze", 1'b1, bod_enable)
      cpu_doze <= 1'b0;
      repeat (3) @(posedge clk_sys);
      `CHK("sleep", 1'b0, bod_enable)
      cpu_awake <= 1'b1;
      bus(1'b1, ADDR_CTRL, 32'h8);
      repeat (2) @(posedge clk_sys);
      bod_below <= 1'b1;
      repeat (3) @(posedge clk_sys);
      `CHK("bodrst", 1'b0, core_rst_b)
      bod_below <= 1'b0;
      wait_run;
      cause(4'h8);
   endtask : t_bod
   task end_sim;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   // ---------
   // sequence
   // ---------
   initial begin
      {rst_b, supply_low, bod_below, cpu_doze, p_go, p_len, avm_req} = '0;
      cpu_awake = 1'b1;
      fails = 0;
      n_checks = 0;
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      wait_run;
      cause(4'h1);
      t_opts;
      t_por;
      t_ext;
      t_sw;
      t_bod;
      end_sim;
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      fails++;
      end_sim;
   end
endmodule : crs_tb_top
